// *** rtl/tws_regs.vh ***
// Register addresses, field positions, reset values and counts of the
// two-channel three-wire serial block.
// Assumes it is included by its bare name from the design files.
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Channel 0 register addresses.
`define TWS_ADDR_MODE0 16'hff80
`define TWS_ADDR_CSEL0 16'hff81
`define TWS_ADDR_SHIFT0 16'hff84
`define TWS_ADDR_TXBUF0 16'hff85

// Channel 1 register addresses.
`define TWS_ADDR_MODE1 16'hff88
`define TWS_ADDR_CSEL1 16'hff89
`define TWS_ADDR_SHIFT1 16'hff8c
`define TWS_ADDR_TXBUF1 16'hff8d

// Reset values and writable-bit masks.
`define TWS_MODE_RESET 8'h00
`define TWS_CSEL_RESET 8'h00
`define TWS_SHIFT_RESET 8'h00
`define TWS_RDATA_RESET 8'h00
`define TWS_SCK_IDLE 2'h3
`define TWS_MODE_WMASK0 8'hd0
`define TWS_MODE_WMASK1 8'hf0
`define TWS_CSEL_WMASK 8'h1f

// Operation mode register fields.
`define TWS_BIT_EN 7
`define TWS_BIT_TRMD 6
`define TWS_BIT_SSE 5
`define TWS_BIT_DIR 4

// Clock selection register fields.
`define TWS_BIT_CKP 4
`define TWS_BIT_DAP 3
`define TWS_CKS_HI 2
`define TWS_CKS_LO 0
`define TWS_CKS_SLAVE 3'h7

// Transfer counts and fill values.
`define TWS_DATA_W 8
`define TWS_FIFO_DEPTH 8
`define TWS_FIFO_AW 3
`define TWS_BITS_LAST 3'h7
`define TWS_CNT_ZERO 3'h0
`define TWS_CNT_ONE 3'h1
`define TWS_DIV_ZERO 7'h00
`define TWS_DIV_ONE 7'h01
`define TWS_RX_FILL 8'hff

`endif

// *** rtl/tws_fifo.v ***
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; flush empties it.
`default_nettype none

module tws_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock and reset.
  input wire clk_i,
  input wire resetn_i,
  input wire flush_i,
  // Filling side.
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // Draining side.
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  localparam [AW:0] DEPTH = D[AW:0];
  localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};
  localparam [AW:0] CNT_ZERO = {(AW+1){1'b0}};

  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  reg ready_r;
  reg valid_r;
  wire push = in_valid_i & ready_r;
  wire pop = out_ready_i & valid_r;

  // Ready and valid are registered so the top can expose them directly.
  assign in_ready_o = ready_r;
  assign out_valid_o = valid_r;
  assign out_data_o = mem_r[rp_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
  end

  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i || flush_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= CNT_ZERO;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != DEPTH);
      valid_r <= (cnt_nxt != CNT_ZERO);
    end
  end

endmodule // tws_fifo

`default_nettype wire

// *** rtl/tws_ctrl.v ***
// Two three-wire serial channels, the same but for channel 1's slave select, with their mode and clock
// registers, reached by address through a simple read/write port.
// Assumes pins come from outside the clock domain and software keeps off
// the registers of a channel while its transfer is running.
`include "tws_regs.vh"
`default_nettype none

module tws_ctrl (
  // Clock and reset.
  input wire clk_i,
  input wire resetn_i,
  // Register port.
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  // Per-channel status.
  output wire [1:0] tx_ready_o,
  output wire [1:0] done_o,
  // Serial clock pins, one bit per channel.
  input wire [1:0] sck_i,
  output wire [1:0] sck_o,
  output wire [1:0] sck_oe_n_o,
  // Serial data pins, one bit per channel.
  input wire [1:0] si_i,
  output wire [1:0] so_o,
  output wire [1:0] so_oe_n_o,
  // Slave select of channel 1, active low.
  input wire ssi_n_i
);

  // Pin synchronisers; the third stage only serves edge detection.
  // The clock stages start at the idle level, so no false edge follows reset.
  reg [1:0] sck_s1_r;
  reg [1:0] sck_s2_r;
  reg [1:0] sck_s3_r;
  reg [1:0] si_s1_r;
  reg [1:0] si_s2_r;
  reg ssi_s1_r;
  reg ssi_s2_r;
  reg [7:0] rdata_r;

  wire [15:0] mode_rd_w;
  wire [15:0] csel_rd_w;
  wire [15:0] shift_rd_w;

  assign reg_rdata_o = rdata_r;

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      sck_s1_r <= `TWS_SCK_IDLE;
      sck_s2_r <= `TWS_SCK_IDLE;
      sck_s3_r <= `TWS_SCK_IDLE;
      si_s1_r <= 2'h0;
      si_s2_r <= 2'h0;
      ssi_s1_r <= 1'b1;
      ssi_s2_r <= 1'b1;
    end else begin
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      si_s1_r <= si_i;
      si_s2_r <= si_s1_r;
      ssi_s1_r <= ssi_n_i;
      ssi_s2_r <= ssi_s1_r;
    end
  end

  // Read data is valid in the cycle after the read strobe.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_r <= `TWS_RDATA_RESET;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TWS_ADDR_MODE0: rdata_r <= mode_rd_w[7:0];
        `TWS_ADDR_CSEL0: rdata_r <= csel_rd_w[7:0];
        `TWS_ADDR_SHIFT0: rdata_r <= shift_rd_w[7:0];
        `TWS_ADDR_MODE1: rdata_r <= mode_rd_w[15:8];
        `TWS_ADDR_CSEL1: rdata_r <= csel_rd_w[15:8];
        `TWS_ADDR_SHIFT1: rdata_r <= shift_rd_w[15:8];
        default: rdata_r <= `TWS_RDATA_RESET;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      localparam [15:0] A_MODE = (g == 0) ? `TWS_ADDR_MODE0 : `TWS_ADDR_MODE1;
      localparam [15:0] A_CSEL = (g == 0) ? `TWS_ADDR_CSEL0 : `TWS_ADDR_CSEL1;
      localparam [15:0] A_SHIFT = (g == 0) ? `TWS_ADDR_SHIFT0 : `TWS_ADDR_SHIFT1;
      localparam [15:0] A_TXBUF = (g == 0) ? `TWS_ADDR_TXBUF0 : `TWS_ADDR_TXBUF1;
      localparam [7:0] WMASK = (g == 0) ? `TWS_MODE_WMASK0 : `TWS_MODE_WMASK1;
      localparam HAS_SSI = (g == 1);

      reg [7:0] mode_r;
      reg [7:0] csel_r;
      reg [7:0] sh_r;
      reg [2:0] cnt_r;
      reg [6:0] div_r;
      reg busy_r;
      reg done_r;
      reg rx_pend_r;
      reg sck_r;
      reg so_r;
      reg sck_oe_n_r;
      reg so_oe_n_r;

      wire en = mode_r[`TWS_BIT_EN];
      wire trmd = mode_r[`TWS_BIT_TRMD];
      wire dir = mode_r[`TWS_BIT_DIR];
      wire ckp = csel_r[`TWS_BIT_CKP];
      wire [2:0] cks = csel_r[`TWS_CKS_HI:`TWS_CKS_LO];
      wire slave = (cks == `TWS_CKS_SLAVE);
      wire wr_mode = reg_wr_i && (reg_addr_i == A_MODE);
      wire wr_csel = reg_wr_i && (reg_addr_i == A_CSEL);
      wire wr_txbuf = reg_wr_i && (reg_addr_i == A_TXBUF);
      wire rd_shift = reg_rd_i && (reg_addr_i == A_SHIFT);

      // Select high holds a pending start and freezes a running one.
      wire gate_hi = HAS_SSI && mode_r[`TWS_BIT_SSE] && slave && ssi_s2_r;

      // Half period of the master clock is two to the power of the field.
      wire [6:0] half = `TWS_DIV_ONE << cks;
      wire tick = (div_r == (half - `TWS_DIV_ONE));
      wire m_edge = busy_r && !slave && tick;
      wire m_lead = m_edge && (sck_r == !ckp);
      wire m_trail = m_edge && (sck_r == ckp);
      wire s_ok = busy_r && slave && !gate_hi;
      wire s_lead = s_ok && (sck_s3_r[g] == !ckp) && (sck_s2_r[g] == ckp);
      wire s_trail = s_ok && (sck_s3_r[g] == ckp) && (sck_s2_r[g] == !ckp);
      wire lead = m_lead || s_lead;
      wire trail = m_trail || s_trail;
      // Data in lags two cycles, so a master field below two samples too early.
      wire in_bit = si_s2_r[g];
      wire out_bit = dir ? sh_r[0] : sh_r[7];

      wire f_valid;
      wire f_ready;
      wire [7:0] f_data;
      wire start = en && !busy_r && !gate_hi && (f_valid || rx_pend_r);
      wire pop = start && f_valid;
      wire [7:0] load = f_valid ? f_data : `TWS_RX_FILL;
      wire first_bit = dir ? load[0] : load[7];

      // Queued bytes keep software from waiting on each transfer.
      tws_fifo #(
        .W(`TWS_DATA_W),
        .D(`TWS_FIFO_DEPTH),
        .AW(`TWS_FIFO_AW)
      ) u_txq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .flush_i(!en),
        .in_valid_i(wr_txbuf && en),
        .in_ready_o(f_ready),
        .in_data_i(reg_wdata_i),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_data)
      );

      assign mode_rd_w[8*g+7:8*g] = {mode_r[7:1], busy_r};
      assign csel_rd_w[8*g+7:8*g] = csel_r;
      assign shift_rd_w[8*g+7:8*g] = sh_r;
      assign tx_ready_o[g] = f_ready;
      assign done_o[g] = done_r;
      assign sck_o[g] = sck_r;
      assign sck_oe_n_o[g] = sck_oe_n_r;
      assign so_o[g] = so_r;
      assign so_oe_n_o[g] = so_oe_n_r;

      always @(posedge clk_i) begin
        if (!resetn_i) begin
          mode_r <= `TWS_MODE_RESET;
          csel_r <= `TWS_CSEL_RESET;
          sh_r <= `TWS_SHIFT_RESET;
          cnt_r <= `TWS_CNT_ZERO;
          div_r <= `TWS_DIV_ZERO;
          busy_r <= 1'b0;
          done_r <= 1'b0;
          rx_pend_r <= 1'b0;
          sck_r <= 1'b1;
          so_r <= 1'b0;
          sck_oe_n_r <= 1'b1;
          so_oe_n_r <= 1'b1;
        end else begin
          done_r <= 1'b0;
          if (wr_mode) begin
            mode_r <= reg_wdata_i & WMASK;
          end
          if (wr_csel) begin
            csel_r <= reg_wdata_i & `TWS_CSEL_WMASK;
          end
          if (!en) begin
            // Stopped: the engine is held cleared every cycle.
            busy_r <= 1'b0;
            sh_r <= `TWS_SHIFT_RESET;
            cnt_r <= `TWS_CNT_ZERO;
            div_r <= `TWS_DIV_ZERO;
            rx_pend_r <= 1'b0;
            sck_r <= !ckp;
            so_r <= 1'b0;
          end else if (start) begin
            busy_r <= 1'b1;
            sh_r <= load;
            so_r <= first_bit;
            cnt_r <= `TWS_CNT_ZERO;
            div_r <= `TWS_DIV_ZERO;
            sck_r <= !ckp;
            if (!f_valid) begin
              rx_pend_r <= 1'b0;
            end
          end else if (busy_r) begin
            if (!slave) begin
              div_r <= tick ? `TWS_DIV_ZERO : div_r + `TWS_DIV_ONE;
            end
            if (m_edge) begin
              sck_r <= !sck_r;
            end
            if (lead && (cnt_r != `TWS_CNT_ZERO)) begin
              so_r <= out_bit;
            end
            if (trail) begin
              sh_r <= dir ? {in_bit, sh_r[7:1]} : {sh_r[6:0], in_bit};
              cnt_r <= cnt_r + `TWS_CNT_ONE;
              if (cnt_r == `TWS_BITS_LAST) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
              end
            end
          end else begin
            sck_r <= !ckp;
          end
          // A read arriving with a start still queues the next receive.
          if (rd_shift && en) begin
            rx_pend_r <= 1'b1;
          end
          // Pins are released unless the channel runs in the matching role.
          sck_oe_n_r <= !(en && !slave);
          so_oe_n_r <= !(en && trmd);
        end
      end
    end
  endgenerate

endmodule // tws_ctrl

`default_nettype wire

// *** rtl/tws_unused.v ***
`default_nettype none
`default_nettype wire

// *** verification/tws_ctrl_checker.sv ***
// Concurrent checks of the serial channel block, bound to its top.
// Assumes register writes land on the edge that takes them.
`default_nettype none
module tws_ctrl_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port.
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Pins and status.
  input wire logic [1:0] done_o,
  input wire logic [1:0] sck_oe_n_o,
  input wire logic [1:0] so_oe_n_o,
  input wire logic ssi_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m0_r, m1_r, c0_r, c1_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadows of the setup, so that pin behaviour can be tied to what was written.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      {m0_r, m1_r, c0_r, c1_r} <= 32'h0000_0000;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        16'hff80: m0_r <= reg_wdata_i;
        16'hff88: m1_r <= reg_wdata_i;
        16'hff81: c0_r <= reg_wdata_i;
        16'hff89: c1_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end
  stop_rel_a: assert property ((!m0_r[7])[*4] |-> sck_oe_n_o[0] && so_oe_n_o[0])
    else $error("stopped channel drives a pin");
  no_xfer_a: assert property ((!m0_r[7])[*4] |-> !done_o[0])
    else $error("stopped channel completed a transfer");
  done_pulse_a: assert property (done_o[1] |=> !done_o[1])
    else $error("completion pulse too long");
  mode0_rd_a: assert property (reg_rd_i && reg_addr_i == 16'hff80 |=>
    reg_rdata_o[7:1] == {m0_r[7:6], 1'b0, m0_r[4], 3'h0})
    else $error("mode 0 readback wrong");
  mode1_rd_a: assert property (reg_rd_i && reg_addr_i == 16'hff88 |=>
    reg_rdata_o[7:1] == {m1_r[7:4], 3'h0})
    else $error("mode 1 readback wrong");
  rx_only_a: assert property ((!m0_r[6])[*3] |-> so_oe_n_o[0])
    else $error("data out driven with transmit off");
  master_clk_a: assert property ((m0_r[7] && c0_r[2:0] != 3'h7)[*3] |-> !sck_oe_n_o[0])
    else $error("master clock not driven");
  sel_hold_a: assert property ((m1_r[7] && m1_r[5] && c1_r[2:0] == 3'h7 && ssi_n_i)[*8]
    |-> !done_o[1])
    else $error("transfer ran with select high");
  cover property (done_o[0]);
  cover property (done_o[1]);
  cover property (reg_rd_i && reg_addr_i == 16'hff8c);
endmodule // tws_ctrl_checker
`default_nettype wire

// *** verification/tws_peer.sv ***
// Far-side model: shifts a byte MSB first on the shared serial clock line.
// Assumes the clock idles high; its clock runs only inside a frame.
`default_nettype none
module tws_peer (
  // Line side.
  input wire logic sck_i,
  input wire logic so_i,
  output logic si_o,
  output logic sck_o,
  // Bench control.
  input wire logic go_i,
  input wire logic ld_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_r = 8'h00;
  initial begin
    si_o = 1'b0;
    sck_o = 1'b1;
    rx_o = 8'h00;
  end
  always @(posedge go_i) begin
    // Clock edges stay off the bench clock's sampling edge.
    #1;
    repeat (8) begin
      #16 sck_o = 1'b0;
      #16 sck_o = 1'b1;
    end
    // After the frame the data line stays driven and flips to the inverse.
    #16 si_o = ~si_o;
  end
  always @(posedge ld_i) sh_r = tx_i;
  // Leading edge puts out the next bit; stale bits are inverted, never held.
  always @(negedge sck_i) begin
    si_o = sh_r[7];
    sh_r = {sh_r[6:0], ~sh_r[7]};
  end
  always @(posedge sck_i) rx_o = {rx_o[6:0], so_i};
endmodule // tws_peer
`default_nettype wire

// *** verification/tb_tws_ctrl.sv ***
// Bench of the two-channel serial block: channel 0 master, channel 1 slave.
// Assumes the checker and far-side model are compiled first.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_tws_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ssi_n_i = 1'b1;
  logic [1:0] go = 2'b00;
  logic [1:0] ld = 2'b00;
  logic [7:0] rd_v;
  logic [15:0] txp = 16'h5aa5;
  wire [15:0] rxp;
  wire [7:0] reg_rdata_o;
  wire [1:0] tx_ready_o, done_o, sck_o, sck_oe_n_o, so_o, so_oe_n_o;
  wire [1:0] p_sck, p_si, sck_ln, so_ln;
  int n_mismatch = 0;
  int checks = 0;
  logic [15:0] ra [4] = '{16'hff80, 16'hff88, 16'hff81, 16'hff89};
  logic [31:0] rows [7] = '{32'hff81_ff1f, 32'hff89_ff1f, 32'hff80_7f50, 32'hff88_7f70,
    32'hff83_5500, 32'hff81_0000, 32'hff89_0000};
  // Released data lines float high, as with a pull-up.
  assign sck_ln = (~sck_oe_n_o & sck_o) | (sck_oe_n_o & p_sck);
  assign so_ln = so_o | so_oe_n_o;
  tws_ctrl tws_ctrl_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_ready_o(tx_ready_o), .done_o(done_o), .sck_i(sck_ln),
    .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .si_i(p_si), .so_o(so_o),
    .so_oe_n_o(so_oe_n_o), .ssi_n_i(ssi_n_i));
  tws_peer tws_peer_i [1:0] (.sck_i(sck_ln), .so_i(so_ln), .si_o(p_si), .sck_o(p_sck),
    .go_i(go), .ld_i(ld), .tx_i(txp), .rx_o(rxp));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    rd_v = reg_rdata_o;
  endtask
  task automatic wdone(input int c);
    int k;
    k = 0;
    while (done_o[c] !== 1'b1 && k < 600) begin
      @(posedge clk_i);
      k++;
    end
    `CHK("done", 1'b1, done_o[c])
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    `CHK("oe", 4'hf, {sck_oe_n_o, so_oe_n_o})
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK("rst", 8'h00, rd_v)
    end
    foreach (rows[i]) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16]);
      `CHK("reg", rows[i][7:0], rd_v)
    end
    $display("register test done");
    ld <= 2'b01;
    wr(16'hff81, 8'h02);
    wr(16'hff80, 8'h40);
    wr(16'hff80, 8'hc0);
    wr(16'hff85, 8'h3c);
    wdone(0);
    `CHK("peer", 8'h3c, rxp[7:0])
    rd(16'hff84);
    `CHK("shift", 8'ha5, rd_v)
    wdone(0);
    `CHK("rx only", 8'hff, rxp[7:0])
    wr(16'hff80, 8'hd0);
    wr(16'hff85, 8'h01);
    wdone(0);
    `CHK("lsb", 8'h80, rxp[7:0])
    // Abort in mid-byte must leave nothing behind in the shifter.
    wr(16'hff85, 8'hff);
    repeat (20) @(posedge clk_i);
    wr(16'hff80, 8'h00);
    repeat (3) @(posedge clk_i);
    `CHK("pins", 2'b11, {sck_oe_n_o[0], so_oe_n_o[0]})
    rd(16'hff80);
    `CHK("busy", 8'h00, rd_v)
    rd(16'hff84);
    `CHK("cleared", 8'h00, rd_v)
    $display("master test done");
    wr(16'hff89, 8'h07);
    wr(16'hff88, 8'h60);
    wr(16'hff88, 8'he0);
    ld <= 2'b11;
    wr(16'hff8d, 8'h96);
    repeat (40) @(posedge clk_i);
    rd(16'hff88);
    `CHK("held", 8'he0, rd_v)
    ssi_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    go <= 2'b10;
    wdone(1);
    `CHK("slave tx", 8'h96, rxp[15:8])
    rd(16'hff8c);
    `CHK("slave rx", 8'h5a, rd_v)
    $display("slave test done");
    // A reset in mid-run must bring back idle registers and an empty queue.
    ssi_n_i <= 1'b1;
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    `CHK("rst ready", 2'h3, tx_ready_o)
    rd(16'hff88);
    `CHK("rst mode", 8'h00, rd_v)
    wr(16'hff89, 8'h07);
    wr(16'hff88, 8'h60);
    wr(16'hff88, 8'he0);
    for (int i = 0; i < 7; i++) begin
      wr(16'hff8d, 8'h00);
    end
    @(posedge clk_i);
    `CHK("room", 1'b1, tx_ready_o[1])
    wr(16'hff8d, 8'h00);
    @(posedge clk_i);
    `CHK("full", 1'b0, tx_ready_o[1])
    $display("reset test done");
    give_verdict();
  end
endmodule // tb_tws_ctrl
bind tws_ctrl tws_ctrl_checker tws_ctrl_checker_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .done_o(done_o),
  .sck_oe_n_o(sck_oe_n_o), .so_oe_n_o(so_oe_n_o), .ssi_n_i(ssi_n_i));
`default_nettype wire
